// ==== pkg/nvsq_pkg.sv ====
// Constants and types for the host-side soft sequence controller
// Function
// - Five prefix reads 0E38,31C7,03E0,3C1F,303F then a command read.
// - Host holds write strobe high through all six sequence cycles.
// - Each sequence address is presented in its own chip-select low period.
// - Save enable change persists only after a later manual store; here reset sets save enable back on in host and model even after a store.
package nvsq_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam logic [14:0] SEQ_A0 = 15'h0e38;
    localparam logic [14:0] SEQ_A1 = 15'h31c7;
    localparam logic [14:0] SEQ_A2 = 15'h03e0;
    localparam logic [14:0] SEQ_A3 = 15'h3c1f;
    localparam logic [14:0] SEQ_A4 = 15'h303f;
    localparam logic [14:0] CMD_SAVE_OFF = 15'h03f8;
    localparam logic [14:0] CMD_SAVE_ON = 15'h07f0;
    localparam logic [14:0] CMD_STORE = 15'h0fc0;
    localparam logic [14:0] CMD_RECALL = 15'h0c63;
    localparam int CLK_MHZ = 50;
    localparam int T_CYCLE_NS = 60;
    localparam int CYC_PHASE = (T_CYCLE_NS * CLK_MHZ + 999) / 1000;
    localparam int T_STORE_US = 12500;
    localparam int T_RECALL_US = 50;
    localparam int T_SS_US = 70;
    localparam int CYC_STORE = T_STORE_US * CLK_MHZ;
    localparam int CYC_RECALL = T_RECALL_US * CLK_MHZ;
    localparam int CYC_SS = T_SS_US * CLK_MHZ;
    typedef enum logic [2:0] {
        NVSQ_OP_READ,
        NVSQ_OP_WRITE,
        NVSQ_OP_STORE,
        NVSQ_OP_RECALL,
        NVSQ_OP_SAVE_OFF,
        NVSQ_OP_SAVE_ON
    } nvsq_op_t;
    typedef struct packed {
        nvsq_op_t op;
        logic [14:0] addr;
        logic [7:0] wdata;
    } nvsq_req_t;
    typedef struct packed {
        logic cs_n;
        logic we_n;
        logic oe_n;
        logic [14:0] addr;
    } nvsq_bus_t;
endpackage

// ==== hw/nvsq_host.sv ====
// Host controller driving nvSRAM pins, including soft command sequences
`timescale 1ns/1ns
`default_nettype none
module nvsq_host #(
    parameter int CYC_STORE_P = nvsq_pkg::CYC_STORE,
    parameter int CYC_RECALL_P = nvsq_pkg::CYC_RECALL,
    parameter int CYC_SS_P = nvsq_pkg::CYC_SS
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic req_valid_i,
    input wire nvsq_pkg::nvsq_req_t req_i,
    output logic req_ready_o,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    output logic save_on_o,
    output logic save_dirty_o,
    output nvsq_pkg::nvsq_bus_t bus_o,
    output logic [7:0] data_lines_o,
    output logic data_lines_oe_o,
    input wire logic [7:0] data_lines_i,
    output logic hardware_store_busy_line_o,
    output logic hardware_store_busy_line_oe_o,
    input wire logic hardware_store_busy_line_i
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_GAP, ST_WAIT
    } nvsq_st_t;

    nvsq_st_t state;
    nvsq_pkg::nvsq_req_t cur;
    logic [2:0] pos;
    logic [7:0] phase;
    logic [31:0] wait_cnt;
    logic [7:0] d_meta, d_sync;
    logic hsb_meta, hsb_sync;

    function automatic logic [14:0] seq_addr(input logic [2:0] p,
                                             input logic [14:0] cmd);
        unique case (p)
            3'h0: seq_addr = nvsq_pkg::SEQ_A0;
            3'h1: seq_addr = nvsq_pkg::SEQ_A1;
            3'h2: seq_addr = nvsq_pkg::SEQ_A2;
            3'h3: seq_addr = nvsq_pkg::SEQ_A3;
            3'h4: seq_addr = nvsq_pkg::SEQ_A4;
            default: seq_addr = cmd;
        endcase
    endfunction

    wire is_read = cur.op == nvsq_pkg::NVSQ_OP_READ;
    wire is_write = cur.op == nvsq_pkg::NVSQ_OP_WRITE;
    wire is_cmd = !is_read && !is_write;
    wire [14:0] cmd_addr =
        (cur.op == nvsq_pkg::NVSQ_OP_STORE) ? nvsq_pkg::CMD_STORE :
        (cur.op == nvsq_pkg::NVSQ_OP_RECALL) ? nvsq_pkg::CMD_RECALL :
        (cur.op == nvsq_pkg::NVSQ_OP_SAVE_OFF) ? nvsq_pkg::CMD_SAVE_OFF :
        nvsq_pkg::CMD_SAVE_ON;
    wire [14:0] cyc_addr = is_cmd ? seq_addr(pos, cmd_addr) : cur.addr;
    wire phase_done = phase == 8'(nvsq_pkg::CYC_PHASE - 1);
    wire last_pos = !is_cmd || pos == 3'h5;
    wire busy_high = hsb_sync;
    wire [31:0] wait_len =
        (cur.op == nvsq_pkg::NVSQ_OP_STORE) ? 32'(CYC_STORE_P) :
        (cur.op == nvsq_pkg::NVSQ_OP_RECALL) ? 32'(CYC_RECALL_P) : 32'(CYC_SS_P);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            d_meta <= 8'h00;
            d_sync <= 8'h00;
            hsb_meta <= 1'b1;
            hsb_sync <= 1'b1;
        end else begin
            d_meta <= data_lines_i;
            d_sync <= d_meta;
            hsb_meta <= hardware_store_busy_line_i;
            hsb_sync <= hsb_meta;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ST_IDLE;
            cur <= '0;
            pos <= 3'h0;
            phase <= 8'h00;
            wait_cnt <= 32'h0;
            req_ready_o <= 1'b0;
            rd_valid_o <= 1'b0;
            rd_data_o <= 8'h00;
            save_on_o <= 1'b1;
            save_dirty_o <= 1'b0;
            bus_o <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 15'h0000};
            data_lines_o <= 8'h00;
            data_lines_oe_o <= 1'b0;
            hardware_store_busy_line_o <= 1'b0;
            hardware_store_busy_line_oe_o <= 1'b0;
        end else begin
            rd_valid_o <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    req_ready_o <= busy_high;
                    if (req_valid_i && req_ready_o && busy_high) begin
                        cur <= req_i;
                        pos <= 3'h0;
                        phase <= 8'h00;
                        req_ready_o <= 1'b0;
                        state <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    bus_o.addr <= cyc_addr;
                    bus_o.cs_n <= 1'b0;
                    bus_o.we_n <= !is_write;
                    bus_o.oe_n <= !is_read;
                    data_lines_o <= cur.wdata;
                    data_lines_oe_o <= is_write;
                    phase <= 8'h00;
                    state <= ST_STROBE;
                end
                ST_STROBE: begin
                    phase <= phase + 8'h01;
                    if (phase_done) begin
                        bus_o.cs_n <= 1'b1;
                        bus_o.we_n <= 1'b1;
                        bus_o.oe_n <= 1'b1;
                        data_lines_oe_o <= 1'b0;
                        if (is_read) begin
                            rd_data_o <= d_sync;
                            rd_valid_o <= 1'b1;
                        end
                        phase <= 8'h00;
                        state <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    phase <= phase + 8'h01;
                    if (phase_done) begin
                        if (!last_pos) begin
                            pos <= pos + 3'h1;
                            state <= ST_SETUP;
                        end else if (is_cmd) begin
                            pos <= 3'h0;
                            wait_cnt <= wait_len;
                            if (cur.op == nvsq_pkg::NVSQ_OP_SAVE_OFF) begin
                                save_on_o <= 1'b0;
                                save_dirty_o <= 1'b1;
                            end
                            if (cur.op == nvsq_pkg::NVSQ_OP_SAVE_ON) begin
                                save_on_o <= 1'b1;
                                save_dirty_o <= 1'b1;
                            end
                            if (cur.op == nvsq_pkg::NVSQ_OP_STORE) begin
                                save_dirty_o <= 1'b0;
                            end
                            state <= ST_WAIT;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_WAIT: begin
                    wait_cnt <= wait_cnt - 32'h1;
                    if (wait_cnt <= 32'h1) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    a_prefix_we_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (is_cmd && !bus_o.cs_n) |-> bus_o.we_n)
        else $error("write strobe low during sequence");
    a_addr_order: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state == ST_SETUP && is_cmd && pos == 3'h1) |=> bus_o.addr == nvsq_pkg::SEQ_A1)
        else $error("sequence address order wrong");
    a_cmd_store: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state == ST_SETUP && cur.op == nvsq_pkg::NVSQ_OP_STORE && pos == 3'h5)
        |=> bus_o.addr == nvsq_pkg::CMD_STORE)
        else $error("store command address wrong");
    a_save_default: assert property (@(posedge clk_i)
        $fell(sys_rst_i) |-> save_on_o)
        else $error("save not enabled after reset");
    a_wait_lock: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state == ST_WAIT) |-> bus_o.cs_n && !req_ready_o)
        else $error("access during store wait");
    a_read_oe: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !bus_o.oe_n |-> !bus_o.cs_n && bus_o.we_n && !data_lines_oe_o)
        else $error("bus contention on read");
    a_pos_reset: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state == ST_WAIT) |-> pos == 3'h0)
        else $error("position not cleared");
    a_write_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (!bus_o.we_n) |-> is_write && !bus_o.cs_n)
        else $error("write strobe outside write");
    a_save_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state == ST_GAP && phase_done && pos == 3'h5
         && cur.op == nvsq_pkg::NVSQ_OP_SAVE_OFF) |=> !save_on_o && save_dirty_o)
        else $error("save disable not tracked");
    a_save_on: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state == ST_GAP && phase_done && pos == 3'h5
         && cur.op == nvsq_pkg::NVSQ_OP_SAVE_ON) |=> save_on_o && save_dirty_o)
        else $error("save enable not tracked");
    a_store_clean: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state == ST_GAP && phase_done && pos == 3'h5
         && cur.op == nvsq_pkg::NVSQ_OP_STORE) |=> !save_dirty_o)
        else $error("dirty flag kept after store");
    a_cmd_recall: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state == ST_SETUP && cur.op == nvsq_pkg::NVSQ_OP_RECALL && pos == 3'h5)
        |=> bus_o.addr == nvsq_pkg::CMD_RECALL)
        else $error("recall command address wrong");
    a_busy_refuse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !busy_high |=> !req_ready_o)
        else $error("ready while device busy");

    // One select low period per access
    sequence s_strobe_low;
        !bus_o.cs_n [*3];
    endsequence
    sequence s_strobe_end;
        bus_o.cs_n && bus_o.oe_n && bus_o.we_n;
    endsequence
    a_cs_width: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $fell(bus_o.cs_n) |-> s_strobe_low ##1 s_strobe_end)
        else $error("select low period wrong");
endmodule
`default_nettype wire

// ==== verif/nvsq_dev_model.sv ====
// Behavioural nvSRAM device model with soft sequence decoding
`timescale 1ns/1ns
`default_nettype none
module nvsq_dev_model #(parameter int BUSY_CYC = 10) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire nvsq_pkg::nvsq_bus_t bus_i,
    input wire logic [7:0] host_data_i,
    input wire logic host_oe_i,
    input wire logic host_busy_i,
    input wire logic host_busy_oe_i,
    output logic [7:0] data_o,
    output logic busy_o,
    output logic save_on_o,
    output logic nv_save_o,
    output logic [7:0] store_cnt_o,
    output logic [7:0] recall_cnt_o
);
    logic [7:0] mem [0:32767];
    logic [13:0] seq [0:4];
    logic [2:0] pos;
    logic prev_cs, hiz, storing;
    logic [7:0] last;
    int lock;
    wire fall = prev_cs && !bus_i.cs_n;
    wire [13:0] a14 = bus_i.addr[13:0];
    wire drive = !bus_i.cs_n && !bus_i.oe_n && bus_i.we_n && !hiz && lock == 0;
    assign data_o = host_oe_i ? host_data_i : (drive ? mem[bus_i.addr] : ~last);
    assign busy_o = !(lock != 0 && storing) && !(host_busy_oe_i && !host_busy_i);
    initial begin
        for (int i = 0; i < 32768; i++) mem[i] = i[7:0] ^ 8'h5a;
        seq = '{nvsq_pkg::SEQ_A0[13:0], nvsq_pkg::SEQ_A1[13:0], nvsq_pkg::SEQ_A2[13:0],
            nvsq_pkg::SEQ_A3[13:0], nvsq_pkg::SEQ_A4[13:0]};
    end
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {pos, hiz, storing, lock, store_cnt_o, recall_cnt_o} <= '0;
            {prev_cs, save_on_o, nv_save_o, last} <= {3'b111, 8'h00};
        end else begin
            prev_cs <= bus_i.cs_n;
            last <= data_o;
            if (lock != 0) lock <= lock - 1;
            if (fall && lock == 0) begin
                hiz <= 1'b0;
                if (!bus_i.we_n) pos <= '0;
                else if (pos == 3'd5) begin
                    pos <= '0;
                    if (a14 == nvsq_pkg::CMD_SAVE_OFF[13:0]) save_on_o <= 1'b0;
                    if (a14 == nvsq_pkg::CMD_SAVE_ON[13:0]) save_on_o <= 1'b1;
                    if (a14 == nvsq_pkg::CMD_STORE[13:0]) begin
                        {hiz, storing, lock, nv_save_o} <= {2'b11, BUSY_CYC, save_on_o};
                        store_cnt_o <= store_cnt_o + 8'h01;
                    end
                    if (a14 == nvsq_pkg::CMD_RECALL[13:0]) begin
                        {hiz, storing, lock} <= {2'b10, BUSY_CYC};
                        recall_cnt_o <= recall_cnt_o + 8'h01;
                    end
                end else if (a14 == seq[pos]) pos <= pos + 3'd1;
                else pos <= (a14 == seq[0]) ? 3'd1 : 3'd0;
            end
            if (!bus_i.cs_n && !bus_i.we_n && busy_o && lock == 0) mem[bus_i.addr] <= data_o;
        end
    end
endmodule
`default_nettype wire

// ==== verif/test_nvsq_host.sv ====
// Testbench for the host soft sequence controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("mismatch at %0t: %s", $time, msg); end end
module test_nvsq_host;
    logic clk_i = 0, sys_rst_i = 1, req_valid_i = 0, req_ready_o, rd_valid_o, save_on_o;
    logic save_dirty_o, dq_oe, hsb_o, hsb_oe, hsb_w, m_save, m_nv;
    logic [7:0] rd_data_o, dq_o, dq_w, n_st, n_rc, d;
    nvsq_pkg::nvsq_req_t req_i = '0;
    nvsq_pkg::nvsq_bus_t bus_o;
    int num_errors = 0, checks = 0, cyc = 0;
    nvsq_host #(.CYC_STORE_P(20), .CYC_RECALL_P(20), .CYC_SS_P(8)) nvsq_host_i (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
        .save_on_o(save_on_o), .save_dirty_o(save_dirty_o), .bus_o(bus_o),
        .data_lines_o(dq_o), .data_lines_oe_o(dq_oe), .data_lines_i(dq_w),
        .hardware_store_busy_line_o(hsb_o), .hardware_store_busy_line_oe_o(hsb_oe),
        .hardware_store_busy_line_i(hsb_w));
    nvsq_dev_model nvsq_dev_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_o),
        .host_data_i(dq_o), .host_oe_i(dq_oe), .host_busy_i(hsb_o), .host_busy_oe_i(hsb_oe),
        .data_o(dq_w), .busy_o(hsb_w), .save_on_o(m_save), .nv_save_o(m_nv),
        .store_cnt_o(n_st), .recall_cnt_o(n_rc));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic end_sim;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            $display("mismatch at %0t: run limit reached", $time);
            end_sim();
        end
    end
    task automatic wait_idle;
        for (int n = 0; n < 2000 && req_ready_o !== 1'b1; n++) @(posedge clk_i) #2;
        `CHK(req_ready_o, 1'b1, "controller did not return to idle")
    endtask
    task automatic issue(input nvsq_pkg::nvsq_op_t op, input logic [14:0] a,
            input logic [7:0] wd, output logic [7:0] rd);
        wait_idle();
        req_valid_i = 1'b1;
        req_i = '{op: op, addr: a, wdata: wd};
        @(posedge clk_i) #2;
        req_valid_i = 1'b0;
        for (int n = 0; n < 100 && op == nvsq_pkg::NVSQ_OP_READ && rd_valid_o !== 1'b1; n++)
            @(posedge clk_i) #2;
        if (op == nvsq_pkg::NVSQ_OP_READ) `CHK(rd_valid_o, 1'b1, "read answer")
        rd = rd_data_o;
    endtask
    task automatic t_reset;
        `CHK(save_on_o, 1'b1, "save enable after reset")
        `CHK(save_dirty_o, 1'b0, "dirty after reset")
    endtask
    task automatic t_rw;
        issue(nvsq_pkg::NVSQ_OP_WRITE, 15'h1234, 8'ha5, d);
        issue(nvsq_pkg::NVSQ_OP_READ, 15'h1234, 8'h00, d);
        `CHK(d, 8'ha5, "read back")
        issue(nvsq_pkg::NVSQ_OP_READ, 15'h0e38, 8'h00, d);
        `CHK(d, 8'h38 ^ 8'h5a, "prefix read data")
    endtask
    task automatic t_save;
        issue(nvsq_pkg::NVSQ_OP_SAVE_OFF, 15'h0000, 8'h00, d);
        wait_idle();
        `CHK({m_save, save_on_o, save_dirty_o, m_nv}, 4'b0011, "save off")
        issue(nvsq_pkg::NVSQ_OP_STORE, 15'h0000, 8'h00, d);
        for (int n = 0; n < 50 && hsb_w !== 1'b0; n++) @(posedge clk_i) #2;
        `CHK(req_ready_o, 1'b0, "ready during store")
        wait_idle();
        `CHK({n_st, m_nv, save_dirty_o}, {8'h01, 2'b00}, "store done")
        issue(nvsq_pkg::NVSQ_OP_SAVE_ON, 15'h0000, 8'h00, d);
        wait_idle();
        `CHK({m_save, save_on_o, m_nv}, 3'b110, "save on")
    endtask
    task automatic t_recall_topbit;
        issue(nvsq_pkg::NVSQ_OP_RECALL, 15'h0000, 8'h00, d);
        wait_idle();
        `CHK(n_rc, 8'h01, "recall")
        t_seq_reads(15'h4000, nvsq_pkg::NVSQ_OP_READ);
        `CHK(n_rc, 8'h02, "top address bit ignored")
    endtask
    task automatic t_seq_reads(input logic [14:0] top, input nvsq_pkg::nvsq_op_t last_op);
        logic [14:0] s [0:4];
        s = '{nvsq_pkg::SEQ_A0, nvsq_pkg::SEQ_A1, nvsq_pkg::SEQ_A2, nvsq_pkg::SEQ_A3,
            nvsq_pkg::SEQ_A4};
        for (int i = 0; i < 5; i++) issue(nvsq_pkg::NVSQ_OP_READ, s[i] | top, 8'h00, d);
        issue(last_op, nvsq_pkg::CMD_RECALL | top, 8'h00, d);
        wait_idle();
        // Plain reads bypass the command wait; let a triggered recall finish
        repeat (16) @(posedge clk_i) #2;
    endtask
    task automatic t_abort;
        t_seq_reads(15'h0000, nvsq_pkg::NVSQ_OP_WRITE);
        `CHK(n_rc, 8'h02, "write aborts sequence")
    endtask
    task automatic t_mid_reset;
        issue(nvsq_pkg::NVSQ_OP_SAVE_OFF, 15'h0000, 8'h00, d);
        wait_idle();
        sys_rst_i = 1'b1;
        repeat (2) @(posedge clk_i) #2;
        sys_rst_i = 1'b0;
        `CHK({m_save, save_on_o, save_dirty_o, req_ready_o}, 4'b1100, "mid reset")
        wait_idle();
        `CHK({save_on_o, save_dirty_o}, 2'b10, "after mid reset")
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        #2 sys_rst_i = 1'b0;
        wait_idle();
        t_reset();
        t_rw();
        t_save();
        t_recall_topbit();
        t_abort();
        t_mid_reset();
        end_sim();
    end
endmodule
`default_nettype wire
